// *** core/pin_irq_pkg.sv ***
// Shared constants and types for the pin interrupt and glitch filter port
package pin_irq_pkg;

  // Pins per port
  localparam int PINS = 8;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;     // Port irq control
  localparam logic [11:0] OFS_PIN_EN = 12'h004;   // Pin irq enables
  localparam logic [11:0] OFS_FLAGS = 12'h008;    // Pin irq flags, w1c
  localparam logic [11:0] OFS_POL = 12'h00c;      // Polarity select
  localparam logic [11:0] OFS_PULL = 12'h010;     // Pull enables
  localparam logic [11:0] OFS_FLT_EN = 12'h014;   // Filter enables
  localparam logic [11:0] OFS_FLT_CTRL = 12'h018; // Filter clock, factor
  localparam logic [11:0] OFS_LEVELS = 12'h01c;   // Filtered pin levels

  //////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_MODE_BIT = 0; // Edge only or edge plus level
  localparam int CTRL_IE_BIT = 1;   // Port interrupt enable
  localparam int CTRL_DMA_BIT = 7;  // Pin DMA request enable
  localparam int FC_FILTER_CLOCK_SELECT_BIT = 7;   // Filter clock select
  localparam int FC_FF_LSB = 0;     // Filter factor low bit
  localparam int FF_W = 5;          // Filter factor width
  localparam int FCNT_W = 6;        // Filter counter width

  // Value of every control field after reset
  localparam logic [7:0] RST_BYTE = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // APB request and answer
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  //////////////////////////////////////////////////////////////////////////
  // Glitch filter state
  typedef enum logic [0:0] {
    FLT_STABLE = 1'b0, // Input agrees with output
    FLT_PEND = 1'b1    // Input differs, counting
  } flt_state_t;

  typedef struct packed {
    flt_state_t st;
    logic [FCNT_W-1:0] cnt;
    logic out;
  } flt_t;

  localparam flt_t FLT_RESET = '{st: FLT_STABLE, cnt: '0, out: 1'b0};

endpackage : pin_irq_pkg

// *** core/glitch_filter.sv ***
// One pin's programmable digital glitch filter
`timescale 1ns/1ps
module glitch_filter (
  input wire logic mclk,                      // Bus clock
  input wire logic rst_n,                     // Sync reset, active low
  input wire logic raw_in,                    // Pad level
  input wire logic enable,                    // Filter in path
  input wire logic tick,                      // Filter clock count enable
  input wire logic [pin_irq_pkg::FF_W-1:0] factor, // Filter factor
  output logic filt_out                       // Filtered level
);
  import pin_irq_pkg::*;

  flt_t s_q; // Whole state
  flt_t s_d; // Next state
  logic [FCNT_W-1:0] limit; // Ticks absorbed: factor plus one

  assign limit = {1'b0, factor} + FCNT_W'(1);
  assign filt_out = s_q.out;

  //////////////////////////////////////////////////////////////////////////
  // Next state: a level must outlast the limit before it passes
  always_comb begin
    s_d = s_q;
    if (!enable) begin
      // Bypass: input passes through one flop
      s_d.st = FLT_STABLE;
      s_d.cnt = '0;
      s_d.out = raw_in;
    end else if (raw_in == s_q.out) begin
      // Pulse returned to prior level: absorbed
      s_d.st = FLT_STABLE;
      s_d.cnt = '0;
    end else if (tick) begin
      case (s_q.st)
        FLT_STABLE: begin
          s_d.st = FLT_PEND;
          s_d.cnt = FCNT_W'(1);
        end
        FLT_PEND: begin
          if (s_q.cnt == limit) begin
            // Outlasted the widest absorbed glitch
            s_d.out = raw_in;
            s_d.st = FLT_STABLE;
            s_d.cnt = '0;
          end else begin
            s_d.cnt = s_q.cnt + FCNT_W'(1);
          end
        end
        default: s_d = FLT_RESET;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= FLT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_filt_pass_width: assert property (
    (enable && $past(enable) && $changed(filt_out)) |->
      $past(s_q.cnt) == $past(limit))
    else $error("filter output changed before the factor width");

  a_filt_bypass_path: assert property (
    !enable |=> filt_out == $past(raw_in))
    else $error("disabled filter did not pass the pad level");

endmodule : glitch_filter

// *** core/pin_irq_port.sv ***
// Port pin interrupt detector, pull select and glitch filters with APB
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module pin_irq_port (
  input wire logic mclk,                       // Bus clock, 200 MHz
  input wire logic rst_n,                      // Sync reset, active low
  input wire pin_irq_pkg::apb_req_t apb_req,   // APB request
  output pin_irq_pkg::apb_rsp_t apb_rsp,       // APB answer
  input wire logic [7:0] pad_in,               // True pad levels
  input wire logic [7:0] digital_cfg,          // Pin set for digital use
  input wire logic [7:0] port_owns,            // Port logic owns pin
  input wire logic low_power_oscillator_clock, // Slow clock, sampled
  input wire logic stop_mode,                  // Device in stop mode
  input wire logic dma_done,                   // DMA finished request
  output logic [7:0] dir_force_in,             // Force pin to input
  output logic [7:0] pull_up_sel,              // Select pullup
  output logic [7:0] pull_down_sel,            // Select pulldown
  output logic [7:0] pull_sel_by_port,         // Port decides pull
  output logic [7:0] filtered_in,              // Filtered input to modules
  output logic cpu_irq,                        // Interrupt to CPU
  output logic dma_req                         // Pin DMA request
);
  import pin_irq_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // All state of the port but the pin filters in one record
  typedef struct packed {
    logic pin_dma_request_enable; // DMA instead of CPU interrupt, outside stop mode
    logic port_irq_enable;        // CPU interrupt allowed
    logic level_sense_select;     // 1: edges and levels
    logic [7:0] pin_irq_enable_bits; // Per-pin sources
    logic [7:0] pin_irq_flags;       // Sticky detections
    logic [7:0] polarity_select_reg; // Per-pin polarity
    logic [7:0] pull_enable_bits;    // Pull resistors on
    logic [7:0] glitch_filter_enable; // Per-pin filter on
    logic filter_clock_select;        // 1: slow clock
    logic [FF_W-1:0] filter_factor;   // Glitch width minus one
    logic [7:0] prev_active;          // Last sampled asserted levels
    logic lpo_prev;                   // Last slow clock sample
    logic [31:0] prdata;              // Read data, from flops
  } port_state_t;

  localparam port_state_t PORT_RESET = '0;

  port_state_t s_q; // Registered state
  port_state_t s_d; // Next state

  //////////////////////////////////////////////////////////////////////////
  // Signals between the pieces
  logic [7:0] flt_on;      // Filter really in the path
  logic lpo_tick;          // One bus cycle per slow clock rise
  logic flt_tick;          // Count enable of every filter
  logic [7:0] active_lvl;  // Filtered input at its asserted level
  logic [7:0] raw_active;  // Pad at its asserted level, unclocked
  logic [7:0] edge_seen;   // New assertion since last cycle
  logic [7:0] set_vec;     // Flags set this cycle
  logic [7:0] clr_vec;     // Flags cleared this cycle
  logic any_flag;          // At least one flag up
  logic stop_wake;         // Level wake while clocks are stopped
  logic acc;               // APB access phase
  logic wr;                // APB write taking effect
  logic [31:0] rd_mux;     // Read data for the addressed register
  logic hit;               // Address is mapped

  //////////////////////////////////////////////////////////////////////////
  // Filter clock: the slow clock only gates counting, so no second
  // domain is needed; its input is taken as synchronous.
  assign lpo_tick = low_power_oscillator_clock & ~s_q.lpo_prev;
  assign flt_tick = s_q.filter_clock_select ? lpo_tick : 1'b1;

  // Filters only act on digital pins
  assign flt_on = s_q.glitch_filter_enable & digital_cfg;

  // One filter per pin, all sharing the clock and factor
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_flt
      glitch_filter u_flt (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw_in(pad_in[g]),
        .enable(flt_on[g]),
        .tick(flt_tick),
        .factor(s_q.filter_factor),
        .filt_out(filtered_in[g])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Detection. The pad is seen whoever owns the pin, so a module
  // sharing the pin does not hide its activity from the detector.
  assign active_lvl = ~(filtered_in ^ s_q.polarity_select_reg);
  assign raw_active = ~(pad_in ^ s_q.polarity_select_reg);
  // Previous level is tracked on every pin, enabled or not; a polarity
  // change on an enabled pin still looks like an edge, which is why the
  // setup order clears the flags before any request is enabled.
  assign edge_seen = active_lvl & ~s_q.prev_active;

  // Set sources: edge always, level only in level mode
  always_comb begin
    set_vec = s_q.pin_irq_enable_bits & edge_seen;
    if (s_q.level_sense_select) begin
      set_vec = set_vec | (s_q.pin_irq_enable_bits & active_lvl);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode. Reads are captured in the setup cycle so the data
  // leaves a flop with no wait state.
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite & hit;

  // Address decode and read mux
  always_comb begin
    hit = 1'b1;
    rd_mux = '0;
    case (apb_req.paddr)
      OFS_CTRL: begin
        rd_mux[CTRL_DMA_BIT] = s_q.pin_dma_request_enable;
        rd_mux[CTRL_IE_BIT] = s_q.port_irq_enable;
        rd_mux[CTRL_MODE_BIT] = s_q.level_sense_select;
      end
      OFS_PIN_EN: rd_mux[7:0] = s_q.pin_irq_enable_bits;
      OFS_FLAGS: rd_mux[7:0] = s_q.pin_irq_flags;
      OFS_POL: rd_mux[7:0] = s_q.polarity_select_reg;
      OFS_PULL: rd_mux[7:0] = s_q.pull_enable_bits;
      OFS_FLT_EN: rd_mux[7:0] = s_q.glitch_filter_enable;
      OFS_FLT_CTRL: begin
        rd_mux[FC_FILTER_CLOCK_SELECT_BIT] = s_q.filter_clock_select;
        rd_mux[FC_FF_LSB +: FF_W] = s_q.filter_factor;
      end
      OFS_LEVELS: rd_mux[7:0] = filtered_in;
      default: hit = 1'b0; // Unmapped: error answer, reads zero
    endcase
  end

  // Flag clears: write one, or DMA done clears them all
  always_comb begin
    clr_vec = '0;
    if (wr && apb_req.paddr == OFS_FLAGS) begin
      clr_vec = apb_req.pwdata[7:0];
    end
    if (dma_done) begin
      clr_vec = 8'hff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Next state of the whole port
  always_comb begin
    s_d = s_q;
    s_d.lpo_prev = low_power_oscillator_clock;
    s_d.prev_active = active_lvl;
    // Set wins over clear, so a held level keeps its flag in level mode
    s_d.pin_irq_flags = (s_q.pin_irq_flags & ~clr_vec) | set_vec;
    if (apb_req.psel && !apb_req.penable) begin
      s_d.prdata = rd_mux;
    end
    if (wr) begin
      case (apb_req.paddr)
        OFS_CTRL: begin
          s_d.pin_dma_request_enable = apb_req.pwdata[CTRL_DMA_BIT];
          s_d.port_irq_enable = apb_req.pwdata[CTRL_IE_BIT];
          s_d.level_sense_select = apb_req.pwdata[CTRL_MODE_BIT];
        end
        OFS_PIN_EN: s_d.pin_irq_enable_bits = apb_req.pwdata[7:0];
        OFS_POL: s_d.polarity_select_reg = apb_req.pwdata[7:0];
        OFS_PULL: s_d.pull_enable_bits = apb_req.pwdata[7:0];
        OFS_FLT_EN: s_d.glitch_filter_enable = apb_req.pwdata[7:0];
        OFS_FLT_CTRL: begin
          // Shared by all filters; only safe with every filter off
          s_d.filter_clock_select = apb_req.pwdata[FC_FILTER_CLOCK_SELECT_BIT];
          s_d.filter_factor = apb_req.pwdata[FC_FF_LSB +: FF_W];
        end
        default: s_d = s_d; // Flags handled above
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= PORT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus answer: zero wait states
  // An unmapped address is refused through pslverr, but the access
  // still ends in its first cycle so the bus can never hang here.
  always_comb begin
    apb_rsp.prdata = s_q.prdata;
    apb_rsp.pready = 1'b1;
    apb_rsp.pslverr = acc & ~hit;
  end

  //////////////////////////////////////////////////////////////////////////
  // Requests. In stop mode the clocked detector is dead, so enabled
  // pad levels wake the CPU straight through, past the DMA enable.
  assign any_flag = |s_q.pin_irq_flags;
  assign stop_wake = stop_mode & |(s_q.pin_irq_enable_bits & raw_active);

  always_comb begin
    dma_req = any_flag & s_q.pin_dma_request_enable & ~stop_mode;
    cpu_irq = any_flag & s_q.port_irq_enable
              & ~s_q.pin_dma_request_enable;
    if (stop_mode) begin
      cpu_irq = s_q.port_irq_enable & (any_flag | stop_wake);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin control. The polarity only matters for pulls that this port
  // itself owns; elsewhere the owning module decides.
  assign dir_force_in = port_owns & s_q.pin_irq_enable_bits;
  assign pull_sel_by_port = port_owns & s_q.pin_irq_enable_bits
                            & s_q.pull_enable_bits;
  assign pull_up_sel = pull_sel_by_port & ~s_q.polarity_select_reg;
  assign pull_down_sel = pull_sel_by_port & s_q.polarity_select_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // A clear attempt on a pin that is still asserted in level mode
  sequence s_level_clear_try;
    s_q.level_sense_select && (|(clr_vec & s_q.pin_irq_enable_bits
                                 & active_lvl));
  endsequence

  sequence s_flag_kept;
    ##1 ((s_q.pin_irq_flags & $past(clr_vec & s_q.pin_irq_enable_bits
          & active_lvl)) == $past(clr_vec & s_q.pin_irq_enable_bits
          & active_lvl));
  endsequence

  a_flag_edge_set: assert property (
    (|set_vec) |=> ((s_q.pin_irq_flags & $past(set_vec))
                    == $past(set_vec)))
    else $error("detected condition did not set its flag");

  a_level_flag_hold: assert property (
    s_level_clear_try |-> s_flag_kept)
    else $error("asserted level let its flag clear");

  a_w1c_clears: assert property (
    (wr && apb_req.paddr == OFS_FLAGS && set_vec == 8'h00) |=>
      (s_q.pin_irq_flags & $past(apb_req.pwdata[7:0])) == 8'h00)
    else $error("write one did not clear the flag");

  a_dma_done_clear: assert property (
    (dma_done && set_vec == 8'h00) |=> s_q.pin_irq_flags == 8'h00)
    else $error("DMA done left a flag set");

  a_dma_blocks_cpu: assert property (
    (!stop_mode && s_q.pin_dma_request_enable && any_flag) |->
      dma_req && !cpu_irq)
    else $error("DMA enable did not steer the request");

  a_stop_wake_cpu: assert property (
    (stop_mode && s_q.port_irq_enable && |(s_q.pin_irq_enable_bits
      & raw_active)) |-> cpu_irq && !dma_req)
    else $error("stop mode level did not reach the CPU");

  a_pull_exclusive: assert property (
    (pull_up_sel & pull_down_sel) == 8'h00 &&
    ((pull_up_sel | pull_down_sel) & ~(port_owns
      & s_q.pin_irq_enable_bits)) == 8'h00)
    else $error("pull select outside the owned irq pins");

  a_no_edge_unset: assert property (
    (!s_q.level_sense_select && $past(active_lvl) == active_lvl
     && clr_vec == 8'h00) |=> s_q.pin_irq_flags == $past(s_q.pin_irq_flags))
    else $error("flag moved with no edge in edge mode");

  a_apb_unmapped: assert property (
    (acc && !hit) |-> apb_rsp.pslverr)
    else $error("unmapped access not refused");

  a_slow_tick_only: assert property (
    (s_q.filter_clock_select && !low_power_oscillator_clock) |-> !flt_tick)
    else $error("filters counted without a slow clock rise");

  // A flag that comes up belongs to a pin enabled in the cycle before
  a_new_flag_enabled: assert property (
    (s_q.pin_irq_flags & ~$past(s_q.pin_irq_flags)
     & ~$past(s_q.pin_irq_enable_bits)) == 8'h00)
    else $error("flag set on a pin that was not enabled");

  // Outside stop mode the port enable gates the CPU request
  a_cpu_gate_ie: assert property (
    (!stop_mode && !s_q.port_irq_enable) |-> !cpu_irq)
    else $error("CPU request without the port enable");

  // With every flag clear nothing is requested outside stop mode
  a_no_flag_quiet: assert property (
    (!stop_mode && s_q.pin_irq_flags == 8'h00) |-> !cpu_irq && !dma_req)
    else $error("request raised with every flag clear");

  // Stop mode never asks for DMA, whatever the enable says
  a_stop_no_dma: assert property (
    stop_mode |-> !dma_req)
    else $error("DMA request raised in stop mode");

  // Unmapped reads return zero and unmapped writes leave the pin enables unchanged
  a_unmapped_rd_zero: assert property (
    (apb_req.psel && !apb_req.penable && !hit) |=> apb_rsp.prdata == 32'h0)
    else $error("unmapped read returned data");

  a_unmapped_wr_drop: assert property (
    (acc && apb_req.pwrite && !hit) |=>
      s_q.pin_irq_enable_bits == $past(s_q.pin_irq_enable_bits))
    else $error("unmapped write changed the pin enables");

endmodule : pin_irq_port

// *** test/dma_engine_model.sv ***
// DMA engine model that answers the pin DMA request after a delay
`timescale 1ns/1ps
module dma_engine_model (
  input wire logic mclk,      // Bus clock
  input wire logic rst_n,     // Sync reset, active low
  input wire logic dma_req,   // Pin DMA request
  input wire logic [3:0] lat, // Answer delay in cycles
  output logic dma_done       // One-cycle done pulse
);
  logic [3:0] cnt_q; // Cycles spent on the current request

  //////////////////////////////////////////////////////////////////////////
  // Count while requested, pulse done once the delay has run out
  always_ff @(posedge mclk) begin
    if (!rst_n || !dma_req) begin
      cnt_q <= 4'h0;
      dma_done <= 1'b0;
    end else begin
      // Done is a pulse so a stuck flag shows up as a repeated request
      dma_done <= (cnt_q == lat);
      cnt_q <= (cnt_q == lat) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule : dma_engine_model

// *** test/pin_irq_port_test.sv ***
// Self-checking bench for the pin interrupt and glitch filter port
`timescale 1ns/1ps
module pin_irq_port_test;
  import pin_irq_pkg::*;
  logic mclk = 1'b0; // Bus clock
  logic rst_n = 1'b0; // Reset, active low
  apb_req_t req = '0; // APB request
  apb_rsp_t rsp; // APB answer
  logic [7:0] pad = 8'h00; // Pad levels
  logic [7:0] dig = 8'hff; // Pins set digital
  logic [7:0] owns = 8'h00; // Port owns pins
  logic [2:0] div_q; // Slow clock divider
  logic stop = 1'b0; // Stop mode
  logic dma_done; // From DMA model
  logic [3:0] dma_lat = 4'h6; // Slow DMA answer
  logic [7:0] force_in; // Forced inputs
  logic [7:0] pu; // Pullup selects
  logic [7:0] pd; // Pulldown selects
  logic [7:0] by_port; // Port decides pull
  logic [7:0] filt; // Filtered levels
  logic cpu_irq; // CPU request
  logic dma_req; // DMA request
  logic [31:0] q; // Last read data
  logic e; // Last error answer
  logic seen; // Filter leak seen
  int error_cnt = 0;
  int n_checks = 0;

  always #2.5 mclk = ~mclk;
  // Slow clock at one eighth of the bus clock
  always_ff @(posedge mclk) div_q <= rst_n ? div_q + 3'h1 : 3'h0;

  pin_irq_port pin_irq_port_inst (.mclk(mclk), .rst_n(rst_n),
    .apb_req(req), .apb_rsp(rsp), .pad_in(pad), .digital_cfg(dig),
    .port_owns(owns), .low_power_oscillator_clock(div_q[2]),
    .stop_mode(stop), .dma_done(dma_done), .dir_force_in(force_in),
    .pull_up_sel(pu), .pull_down_sel(pd), .pull_sel_by_port(by_port),
    .filtered_in(filt), .cpu_irq(cpu_irq), .dma_req(dma_req));

  dma_engine_model dma_engine_model_inst (.mclk(mclk), .rst_n(rst_n),
    .dma_req(dma_req), .lat(dma_lat), .dma_done(dma_done));

  //////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // One APB transfer; waits for pready, then lets one idle edge pass
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge mclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd

  // Ordered pin interrupt setup, flags cleared before enabling requests
  task automatic cfg(input logic [31:0] c, input logic [7:0] en,
                     input logic [7:0] pol);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_POL, {24'h0, pol});
    wr(OFS_PIN_EN, {24'h0, en});
    cyc(3);
    wr(OFS_FLAGS, 32'hff);
    wr(OFS_CTRL, c);
  endtask : cfg

  //////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 8; i++) rd(12'(i * 4), {24'h0, RST_BYTE}, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    wr(12'h020, 32'hff); // Unmapped write is refused and dropped
    chk({31'h0, e}, 32'h1);
    rd(OFS_PIN_EN, 32'h0, 1'b0);
    wr(OFS_PIN_EN, 32'ha5);
    rd(OFS_PIN_EN, 32'ha5, 1'b0);
    wr(OFS_PIN_EN, 32'h0);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_edge;
    cfg(32'h2, 8'h01, 8'h01);
    pad <= 8'h03; // Pin 1 is not enabled
    cyc(3);
    chk(cpu_irq, 1'b1);
    chk(dma_req, 1'b0);
    rd(OFS_FLAGS, 32'h01, 1'b0);
    wr(OFS_FLAGS, 32'h01); // Level still high, edge mode lets go
    cyc(1);
    chk(cpu_irq, 1'b0);
    pad <= 8'h04;
    cfg(32'h0, 8'h04, 8'h00);
    pad <= 8'h00;
    cyc(3);
    rd(OFS_FLAGS, 32'h04, 1'b0);
    chk(cpu_irq, 1'b0);
    wr(OFS_FLAGS, 32'hff);
    pad <= 8'h04;
    cyc(3);
    rd(OFS_FLAGS, 32'h00, 1'b0);
    $display("t_edge done");
  endtask : t_edge

  task automatic t_dma;
    pad <= 8'h00;
    cfg(32'h82, 8'h01, 8'h01);
    pad <= 8'h01;
    cyc(3);
    chk(dma_req, 1'b1);
    chk(cpu_irq, 1'b0);
    cyc(12);
    chk(dma_req, 1'b0);
    rd(OFS_FLAGS, 32'h0, 1'b0);
    $display("t_dma done");
  endtask : t_dma

  task automatic t_level;
    pad <= 8'h00;
    cfg(32'h03, 8'h08, 8'h08);
    pad <= 8'h08;
    cyc(3);
    wr(OFS_FLAGS, 32'h08);
    rd(OFS_FLAGS, 32'h08, 1'b0);
    pad <= 8'h00;
    cyc(2);
    wr(OFS_FLAGS, 32'h08);
    rd(OFS_FLAGS, 32'h00, 1'b0);
    $display("t_level done");
  endtask : t_level

  task automatic t_pull;
    owns <= 8'h30; // Pin 6 belongs to another module
    wr(OFS_CTRL, 32'h0);
    wr(OFS_POL, 32'h20);
    wr(OFS_PULL, 32'h70);
    wr(OFS_PIN_EN, 32'h70);
    cyc(1);
    chk(force_in, 8'h30);
    chk(by_port, 8'h30);
    chk(pu & by_port, 8'h10);
    chk(pd & by_port, 8'h20);
    wr(OFS_PIN_EN, 32'h0);
    chk(pu | pd, 8'h00);
    owns <= 8'h00;
    cyc(1);
    chk(by_port, 8'h00);
    $display("t_pull done");
  endtask : t_pull

  task automatic t_stop;
    pad <= 8'h00;
    cfg(32'h82, 8'h01, 8'h01);
    stop <= 1'b1;
    pad <= 8'h01;
    #1;
    chk(cpu_irq, 1'b1);
    chk(dma_req, 1'b0);
    @(posedge mclk);
    stop <= 1'b0;
    pad <= 8'h00;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FLAGS, 32'hff);
    $display("t_stop done");
  endtask : t_stop

  task automatic t_filter;
    wr(OFS_FLT_EN, 32'h0);
    wr(OFS_FLT_CTRL, 32'h02);
    wr(OFS_FLT_EN, 32'h01);
    cyc(4);
    seen = 1'b0;
    pad <= 8'h01; // Pulse of factor plus one cycles
    cyc(3);
    pad <= 8'h00;
    repeat (10) begin
      @(posedge mclk);
      seen = seen | filt[0];
    end
    chk(seen, 1'b0);
    pad <= 8'h01;
    cyc(8);
    chk(filt[0], 1'b1);
    seen = 1'b1;
    pad <= 8'h00; // Low for factor plus two cycles passes
    cyc(4);
    pad <= 8'h01;
    repeat (10) begin
      @(posedge mclk);
      seen = seen & filt[0];
    end
    chk(seen, 1'b0);
    pad <= 8'h02; // Pin 0 off digital use, pin 1 unfiltered: both pass
    dig <= 8'hfe;
    cyc(1);
    pad <= 8'h01;
    #1;
    chk(filt[1:0], 2'b10);
    @(posedge mclk);
    dig <= 8'hff;
    wr(OFS_FLT_EN, 32'h0);
    wr(OFS_FLT_CTRL, 32'h80);
    wr(OFS_FLT_EN, 32'h04);
    pad <= 8'h05;
    cyc(4);
    chk(filt[2], 1'b0);
    cyc(20);
    chk(filt[2], 1'b1);
    rd(OFS_LEVELS, 32'h05, 1'b0);
    $display("t_filter done");
  endtask : t_filter

  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_edge();
    t_dma();
    t_level();
    t_pull();
    t_stop();
    t_filter();
    close_out();
  end
endmodule : pin_irq_port_test
